/* File: verilog/sbs_ctrl.sv */
`timescale 1ns/1ps
`include "sbs_regs.svh"
module sbs_ctrl #(
  parameter int ADDR_W = `SBS_ADDR_W,
  parameter int LANES  = `SBS_LANES,
  parameter int LANE_W = `SBS_LANE_W
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst_b,
  // Mode pins, already resolved to default levels by pad pulls
  input  wire logic                    burst_order_select,
  input  wire logic                    sleep_request,
  input  wire logic                    deselect_mode_select,
  input  wire logic                    drive_strength_select,
  input  wire logic                    output_enable_n,
  // Synchronous controls
  input  wire sbs_pkg::sbs_ctrl_t      ctrl,
  input  wire logic [ADDR_W-1:0]       addr,
  // Data pin
  input  wire logic [LANES*LANE_W-1:0] dq_in,
  output logic      [LANES*LANE_W-1:0] dq_out_ff,
  output logic      [LANES-1:0]        dq_oe_ff,
  // Status
  output logic                         standby_ff,
  output logic                         high_drive_ff
);
  // Two-stage sync for async pins
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] nxt_sync1;
  logic [3:0] nxt_sync2;
  always_comb begin
    nxt_sync1 = {output_enable_n, sleep_request, deselect_mode_select, drive_strength_select};
    nxt_sync2 = sync1_ff;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      // Reset to the pad defaults: output off, single-cycle deselect, normal drive
      sync1_ff <= 4'hb;
      sync2_ff <= 4'hb;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end
  logic oe_n_s;
  logic sleep_s;
  logic scd_s;
  logic zq_s;
  assign oe_n_s  = sync2_ff[3];
  assign sleep_s = sync2_ff[2];
  assign scd_s   = sync2_ff[1];
  assign zq_s    = sync2_ff[0];

  // Sampled control inputs
  sbs_pkg::sbs_ctrl_t       c_ff;
  sbs_pkg::sbs_ctrl_t       nxt_c;
  logic [ADDR_W-1:0]        a_ff;
  logic [ADDR_W-1:0]        nxt_a;
  logic [LANES*LANE_W-1:0]  d_ff;
  logic [LANES*LANE_W-1:0]  nxt_d;
  always_comb begin
    nxt_c = ctrl;
    nxt_a = addr;
    nxt_d = dq_in;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      c_ff <= '1;
      a_ff <= '0;
      d_ff <= '0;
    end else begin
      c_ff <= nxt_c;
      a_ff <= nxt_a;
      d_ff <= nxt_d;
    end
  end

  // Cycle decode
  logic             en_true;
  logic             wr_q;
  logic [LANES-1:0] lane_sel;
  sbs_pkg::sbs_op_t op;
  logic             load;
  logic             step;
  always_comb begin
    en_true = c_ff.chip_select_hi & ~c_ff.chip_select_aux_n;
    for (int i = 0; i < LANES; i++) begin
      lane_sel[i] = ~c_ff.all_bytes_write_n |
                    (~c_ff.lane_write_gate_n & ~c_ff.lane_write_n[i]);
    end
    wr_q = |lane_sel;
    op   = sbs_pkg::SBS_OP_IDLE;
    load = 1'b0;
    step = 1'b0;
    if (sleep_s) begin
      op = sbs_pkg::SBS_OP_IDLE;
    end else if (!c_ff.chip_select_n && !c_ff.processor_addr_strobe_n) begin
      // Processor strobe reads only with the combined enable false
      op   = en_true ? sbs_pkg::SBS_OP_DESEL : sbs_pkg::SBS_OP_READ;
      load = ~en_true;
    end else if (!c_ff.controller_addr_strobe_n) begin
      if (c_ff.chip_select_n) begin
        op = sbs_pkg::SBS_OP_DESEL;
      end else if (!en_true && !wr_q) begin
        load = 1'b1;
        op   = sbs_pkg::SBS_OP_READ;
      end else if (en_true && wr_q) begin
        load = 1'b1;
        op   = sbs_pkg::SBS_OP_WRITE;
      end else begin
        // Unlisted enable and write mix: treated as deselect, no address used
        op = sbs_pkg::SBS_OP_DESEL;
      end
    end else if (c_ff.processor_addr_strobe_n || c_ff.chip_select_n) begin
      step = ~c_ff.burst_advance_n;
      op   = wr_q ? sbs_pkg::SBS_OP_WRITE : sbs_pkg::SBS_OP_READ;
    end
  end

  // Burst counter
  logic [1:0] start_ff;
  logic [1:0] cnt_ff;
  logic [1:0] nxt_start;
  logic [1:0] nxt_cnt;
  logic [1:0] cur_lo;
  logic [ADDR_W-1:0] mem_addr;
  logic [ADDR_W-1:0] base_ff;
  logic [ADDR_W-1:0] nxt_base;
  always_comb begin
    nxt_start = start_ff;
    nxt_cnt   = cnt_ff;
    nxt_base  = base_ff;
    if (load) begin
      nxt_start = a_ff[1:0];
      nxt_cnt   = `SBS_CNT_RST;
      nxt_base  = a_ff;
    end
    if (burst_order_select) begin
      cur_lo = start_ff ^ cnt_ff;
    end else begin
      cur_lo = 2'(start_ff + cnt_ff);
    end
    mem_addr = load ? a_ff : {base_ff[ADDR_W-1:2], cur_lo};
    if (step) begin
      // Stepping reads and writes alike, whatever the output enable
      nxt_cnt = 2'(cnt_ff + 2'h1);
      mem_addr = {base_ff[ADDR_W-1:2],
                  burst_order_select ? (start_ff ^ nxt_cnt) : 2'(start_ff + nxt_cnt)};
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      start_ff <= `SBS_CNT_RST;
      cnt_ff   <= `SBS_CNT_RST;
      base_ff  <= '0;
    end else begin
      start_ff <= nxt_start;
      cnt_ff   <= nxt_cnt;
      base_ff  <= nxt_base;
    end
  end

  logic [LANES-1:0]        mem_we;
  logic [LANES*LANE_W-1:0] mem_q;
  assign mem_we = (op == sbs_pkg::SBS_OP_WRITE) ? lane_sel : '0;
  sbs_mem #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES),
    .LANE_W (LANE_W)
  ) u_mem (
    .core_clk (core_clk),
    .addr     (mem_addr),
    .lane_we  (mem_we),
    .wdata    (d_ff),
    .rdata_ff (mem_q)
  );

  // Output pipeline; deselect takes one stage less in single-cycle mode
  logic rd1_ff;
  logic nxt_rd1;
  logic rd2_ff;
  logic nxt_rd2;
  logic drive;
  logic [LANES*LANE_W-1:0] nxt_dq;
  logic [LANES-1:0]        nxt_oe;
  always_comb begin
    nxt_rd1 = (op == sbs_pkg::SBS_OP_READ);
    nxt_rd2 = rd1_ff;
    // Single mode cuts drivers as soon as a non-read is captured
    drive   = scd_s ? (rd1_ff & nxt_rd1) : rd1_ff;
    nxt_dq  = mem_q;
    // Output enable gates only; a write never drives the pins
    nxt_oe  = (drive && !oe_n_s && op != sbs_pkg::SBS_OP_WRITE) ? '1 : '0;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rd1_ff        <= 1'b0;
      rd2_ff        <= 1'b0;
      dq_out_ff     <= '0;
      dq_oe_ff      <= '0;
      standby_ff    <= 1'b0;
      high_drive_ff <= 1'b0;
    end else begin
      rd1_ff        <= nxt_rd1;
      rd2_ff        <= nxt_rd2;
      dq_out_ff     <= nxt_dq;
      dq_oe_ff      <= nxt_oe;
      standby_ff    <= sleep_s;
      high_drive_ff <= ~zq_s;
    end
  end
endmodule

/* File: common/sbs_regs.svh */
`ifndef SBS_REGS_SVH
`define SBS_REGS_SVH
`define SBS_LANES        4
`define SBS_LANE_W       8
`define SBS_ADDR_W       18
`define SBS_BURST_LEN    2'h3
`define SBS_CNT_RST      2'h0
`endif

/* File: common/sbs_pkg.sv */
package sbs_pkg;
  typedef struct packed {
    logic       chip_select_n;
    logic       chip_select_hi;
    logic       chip_select_aux_n;
    logic       processor_addr_strobe_n;
    logic       controller_addr_strobe_n;
    logic       burst_advance_n;
    logic       all_bytes_write_n;
    logic       lane_write_gate_n;
    logic [3:0] lane_write_n;
  } sbs_ctrl_t;
  typedef enum logic [2:0] {
    SBS_OP_IDLE,
    SBS_OP_DESEL,
    SBS_OP_READ,
    SBS_OP_WRITE
  } sbs_op_t;
endpackage

/* File: verilog/sbs_mem.sv */
`timescale 1ns/1ps
`include "sbs_regs.svh"
module sbs_mem #(
  parameter int ADDR_W = `SBS_ADDR_W,
  parameter int LANES  = `SBS_LANES,
  parameter int LANE_W = `SBS_LANE_W
) (
  // Clock
  input  wire logic                      core_clk,
  // Port
  input  wire logic [ADDR_W-1:0]         addr,
  input  wire logic [LANES-1:0]          lane_we,
  input  wire logic [LANES*LANE_W-1:0]   wdata,
  output logic      [LANES*LANE_W-1:0]   rdata_ff
);
  logic [LANES*LANE_W-1:0] mem [0:(1<<ADDR_W)-1];
  always_ff @(posedge core_clk) begin
    rdata_ff <= mem[addr];
  end
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    always_ff @(posedge core_clk) begin
      if (lane_we[i]) begin
        mem[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
      end
    end
  end
endmodule

/* File: verification/sbs_ctrl_monitor.sv */
`timescale 1ns/1ps
module sbs_ctrl_monitor #(
  parameter int LANES = 4
) (
  // Clock and modes
  input wire logic               core_clk,
  input wire logic               rst_b,
  input wire logic               sleep_request,
  input wire logic               drive_strength_select,
  input wire logic               output_enable_n,
  input wire sbs_pkg::sbs_ctrl_t ctrl,
  // Outputs
  input wire logic [LANES-1:0]   dq_oe_ff,
  input wire logic               standby_ff,
  input wire logic               high_drive_ff
);
  logic en_ok, wr_q, rd_go, wr_go, hold_rd;
  assign en_ok = ctrl.chip_select_hi && !ctrl.chip_select_aux_n;
  assign wr_q = !ctrl.all_bytes_write_n || (!ctrl.lane_write_gate_n && ctrl.lane_write_n != 4'hf);
  assign rd_go = !ctrl.chip_select_n && !en_ok && (!ctrl.processor_addr_strobe_n
                 || (!ctrl.controller_addr_strobe_n && !wr_q));
  assign wr_go = !ctrl.chip_select_n && en_ok && ctrl.processor_addr_strobe_n
                 && !ctrl.controller_addr_strobe_n && wr_q;
  assign hold_rd = ctrl.processor_addr_strobe_n && ctrl.controller_addr_strobe_n
                   && ctrl.burst_advance_n && !wr_q && !output_enable_n && !sleep_request;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  a_write_no_drive: assert property ((wr_go || (ctrl.processor_addr_strobe_n
    && ctrl.controller_addr_strobe_n && wr_q)) |-> ##2 dq_oe_ff == '0)
    else $error("output driven for a write");
  a_read_drives_all: assert property ((!output_enable_n && !sleep_request)[*3]
    ##0 rd_go ##1 hold_rd[*2] |=> dq_oe_ff == '1) else $error("read not driven");
  a_desel_quiet: assert property ((ctrl.chip_select_n
    && !ctrl.controller_addr_strobe_n)[*3] |=> dq_oe_ff == '0) else $error("deselect drives");
  a_oe_gate: assert property (output_enable_n[*4] |=> dq_oe_ff == '0)
    else $error("drive with output enable off");
  a_sleep_quiet: assert property (sleep_request[*4] |=> standby_ff && dq_oe_ff == '0)
    else $error("standby not entered");
  a_drive_normal: assert property (drive_strength_select[*4] |=> !high_drive_ff)
    else $error("drive level wrong");
  a_drive_high: assert property (!drive_strength_select[*4] |=> high_drive_ff)
    else $error("high drive missing");
  a_lanes_whole: assert property (dq_oe_ff == '0 || dq_oe_ff == '1)
    else $error("partial lane drive");
endmodule
bind sbs_ctrl sbs_ctrl_monitor #(.LANES(LANES)) mon_u (.core_clk(core_clk), .rst_b(rst_b),
  .sleep_request(sleep_request), .drive_strength_select(drive_strength_select),
  .output_enable_n(output_enable_n), .ctrl(ctrl), .dq_oe_ff(dq_oe_ff),
  .standby_ff(standby_ff), .high_drive_ff(high_drive_ff));

/* File: verification/sbs_host.sv */
`timescale 1ns/1ps
`include "sbs_regs.svh"
module sbs_host (
  // Clock
  input wire logic                                 core_clk,
  // Bus toward the memory
  output sbs_pkg::sbs_ctrl_t                       ctrl,
  output logic [`SBS_ADDR_W-1:0]                   addr,
  output logic [`SBS_LANES*`SBS_LANE_W-1:0]        dq_in
);
  initial begin
    ctrl = 12'hb7f;
    addr = '0;
    dq_in = '0;
  end
  // Addresses loaded by either the processor or the controller strobe
  task automatic go(input logic [11:0] c, input logic [17:0] a, input logic [31:0] d);
    @(negedge core_clk);
    ctrl = c;
    addr = a;
    // Released data lines flip, so stale data never looks valid
    dq_in = (!c[5] || (!c[4] && c[3:0] != 4'hf)) ? d : ~dq_in;
  endtask
endmodule

/* File: verification/sync_burst_sram_control_bench.sv */
`timescale 1ns/1ps
module sync_burst_sram_control_bench;
  localparam logic [11:0] DES = 12'hb7f, RD = 12'h2ff, SUS = 12'h5ff, CONT = 12'h5bf;
  typedef struct packed { logic [11:0] c; logic [3:0] a; logic [31:0] d, e; } sbs_row_t;
  sbs_row_t rows [10] = '{'{12'h55f, 0, 32'h1111_1111, 0}, '{12'h55f, 1, 32'h2222_2222, 0},
    '{12'h55f, 2, 32'h3333_3333, 0}, '{12'h550, 3, 32'h4444_4444, 0},
    '{12'h56e, 1, 32'haaaa_aaaa, 0}, '{12'h565, 2, 32'hbbbb_bbbb, 0},
    '{RD, 0, 0, 32'h1111_1111}, '{12'h37f, 1, 0, 32'h2222_22aa},
    '{12'h2ef, 2, 0, 32'hbb33_bb33}, '{RD, 3, 0, 32'h4444_4444}};
  logic [31:0] mem [4] = '{32'h1111_1111, 32'h2222_22aa, 32'hbb33_bb33, 32'h4444_4444};
  logic core_clk, rst_b, order, sleep, dsel, drv, oe_n, standby, hi_drv;
  sbs_pkg::sbs_ctrl_t ctrl;
  logic [17:0] addr;
  logic [31:0] dq_in, dq_out;
  logic [3:0]  oe;
  int          errors, checked;
  sbs_ctrl dut_u (.core_clk(core_clk), .rst_b(rst_b), .burst_order_select(order),
    .sleep_request(sleep), .deselect_mode_select(dsel), .drive_strength_select(drv),
    .output_enable_n(oe_n), .ctrl(ctrl), .addr(addr), .dq_in(dq_in), .dq_out_ff(dq_out),
    .dq_oe_ff(oe), .standby_ff(standby), .high_drive_ff(hi_drv));
  sbs_host host_u (.core_clk(core_clk), .ctrl(ctrl), .addr(addr), .dq_in(dq_in));
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic hold();
    repeat (3) host_u.go(SUS, '0, '0);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
  initial begin
    {rst_b, order, sleep, dsel, drv, oe_n} = 6'b000110;
    repeat (8) host_u.go(DES, '0, '0);
    chk("reset oe", 32'(oe), 0);
    rst_b = 1;
    repeat (4) host_u.go(DES, '0, '0);
    chk("normal drive", 32'(hi_drv), 0);
    foreach (rows[i]) begin
      host_u.go(rows[i].c, 18'(rows[i].a), rows[i].d);
      if (rows[i].e !== '0) begin
        hold();
        chk("read data", dq_out, rows[i].e);
        chk("read lanes", 32'(oe), 32'h0000_000f);
      end else host_u.go(DES, '0, '0);
    end
    dsel = 0;
    for (int m = 0; m < 2; m++) begin
      for (int s = 0; s < 4; s++) begin
        order = m[0];
        host_u.go(RD, 18'(s), '0);
        for (int k = 0; k < 5; k++) begin
          if (k > 0) host_u.go(CONT, '0, '0);
          hold();
          chk("burst", dq_out, mem[m ? (s ^ k) & 3 : (s + k) & 3]);
        end
      end
    end
    oe_n = 1;
    host_u.go(RD, 18'h0_0001, '0);
    repeat (2) host_u.go(CONT, '0, '0);
    hold();
    chk("oe off", 32'(oe), 0);
    oe_n = 0;
    hold();
    chk("dummy read step", dq_out, mem[3]);
    host_u.go(12'h55f, 18'h0_0004, 32'h5555_6666);
    host_u.go(12'h59f, '0, 32'h7777_8888);
    host_u.go(DES, '0, '0);
    host_u.go(RD, 18'h0_0005, '0);
    hold();
    chk("write burst", dq_out, 32'h7777_8888);
    sleep = 1;
    drv = 0;
    repeat (4) host_u.go(DES, '0, '0);
    host_u.go(RD, '0, '0);
    hold();
    chk("standby", 32'({standby, oe}), 32'h0000_0010);
    chk("high drive", 32'(hi_drv), 1);
    end_of_test();
  end
endmodule
